/* verilog/ulmc_core.sv */
// line control, modem control, line status and resume characters of a uart
`timescale 1ns/1ns
`default_nettype none
module ulmc_core #(
  parameter int DIVISOR_DEFAULT = 1
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic por_n_in,
  input wire logic [2:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] wdata_in,
  input wire logic feature_bit2_in,
  input wire logic auto_rts_in,
  input wire logic auto_rts_level_in,
  input wire logic dtr_sel_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  input wire logic rx_fifo_full_in,
  input wire logic rx_fifo_ready_in,
  input wire logic rx_fifo_err_any_in,
  input wire logic [2:0] rx_head_err_in,
  input wire logic rx_pin_in,
  input wire logic cts_n_in,
  input wire logic dsr_n_in,
  input wire logic dcd_n_in,
  input wire logic ri_n_in,
  output logic [7:0] rdata_out,
  output logic divisor_sel_out,
  output logic upper_page_out,
  output logic tx_ready_out,
  output logic rx_push_out,
  output logic [7:0] rx_data_out,
  output logic [2:0] rx_err_out,
  output logic resume_tx_out,
  output logic tx_pin_out,
  output logic rts_n_out,
  output logic dtr_n_out,
  output logic [3:0] modem_in_out
);
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA = 4'b0100,
    TX_STOP = 4'b1000
  } ulmc_tx_e;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } ulmc_rx_e;
  typedef struct packed {
    logic [7:0] lc;
    logic [7:0] mc;
    logic overrun;
    logic [1:0] pre_cnt;
    logic [15:0] baud_cnt;
    logic tick;
    logic [1:0] rx_sync;
    logic [3:0] cts_sync;
    ulmc_tx_e tx_st;
    logic thr_full;
    logic [7:0] tx_holding_reg;
    logic [8:0] tx_shift_reg;
    logic [3:0] tx_bits;
    logic [4:0] tx_ticks;
    logic [3:0] tx_sub;
    logic tx_line;
    ulmc_rx_e rx_st;
    logic [3:0] rx_sub;
    logic [3:0] rx_bits;
    logic [8:0] rsr;
    logic rx_zero;
    logic rx_push;
    logic [7:0] rx_data;
    logic [2:0] rx_err;
    logic resume;
    logic [7:0] rdata;
    logic rts_n;
    logic dtr_n;
    logic [3:0] modem_in;
    logic [5:0] pin_sync;
    logic tx_pin;
    logic upper_page;
  } ulmc_state_s;
  ulmc_state_s s_reg, s_next;
  logic [7:0] res1_reg, res1_next, res2_reg, res2_next;
  logic [7:0] ls;
  logic [3:0] nbits;
  logic rx_in_bit, resume_page, par_bit;
  logic [5:0] stop_len;

  always_comb begin
    nbits = 4'h5 + {2'b00, s_reg.lc[1:0]};
    resume_page = (s_reg.lc == ulmc_pkg::RESUME_PAGE_KEY) && !feature_bit2_in;
    // loopback takes the internal line; outside loopback, infrared inverts the idle sense
    rx_in_bit = s_reg.mc[ulmc_pkg::MC_LOOPBACK] ? s_reg.tx_line : s_reg.rx_sync[1];
    if (s_reg.mc[ulmc_pkg::MC_INFRARED] && !s_reg.mc[ulmc_pkg::MC_LOOPBACK]) begin
      rx_in_bit = ~rx_in_bit;
    end
    if (s_reg.lc[ulmc_pkg::LC_FORCE_PAR]) begin
      par_bit = ~s_reg.lc[ulmc_pkg::LC_EVEN_PAR];
    end else begin
      // only the bits of the chosen length count
      par_bit = ^(s_reg.tx_holding_reg & (8'hFF >> (4'd8 - nbits)))
        ^ ~s_reg.lc[ulmc_pkg::LC_EVEN_PAR];
    end
    // stop length in ticks, six bits so two full stops do not wrap
    stop_len = 6'(ulmc_pkg::FULL_STOP_TICKS);
    if (s_reg.lc[ulmc_pkg::LC_STOP]) begin
      if (s_reg.lc[1:0] == 2'b00) begin
        stop_len = stop_len + 6'(ulmc_pkg::HALF_STOP_TICKS);
      end else begin
        stop_len = stop_len + 6'(ulmc_pkg::FULL_STOP_TICKS);
      end
    end
    ls = '0;
    ls[ulmc_pkg::LS_FIFO_ERR] = rx_fifo_err_any_in;
    ls[ulmc_pkg::LS_TX_IDLE] = !s_reg.thr_full && (s_reg.tx_st == TX_IDLE);
    ls[ulmc_pkg::LS_THR_EMPTY] = !s_reg.thr_full;
    ls[ulmc_pkg::LS_BREAK] = rx_head_err_in[2];
    ls[ulmc_pkg::LS_FRAMING] = rx_head_err_in[1];
    ls[ulmc_pkg::LS_PARITY] = rx_head_err_in[0];
    ls[ulmc_pkg::LS_OVERRUN] = s_reg.overrun;
    ls[ulmc_pkg::LS_READY] = rx_fifo_ready_in;
  end

  always_comb begin
    s_next = s_reg;
    res1_next = res1_reg;
    res2_next = res2_reg;
    s_next.rx_push = 1'b0;
    s_next.resume = 1'b0;
    s_next.rx_sync = {s_reg.rx_sync[0], rx_pin_in};
    s_next.cts_sync = {s_reg.cts_sync[1:0], cts_n_in, 1'b0};
    // modem status pins pass two stages before use
    s_next.pin_sync = {s_reg.pin_sync[2:0], dcd_n_in, ri_n_in, dsr_n_in};
    // register writes
    if (wr_in) begin
      if (addr_in == ulmc_pkg::OFS_LINE_CONTROL) begin
        s_next.lc = wdata_in;
      end else if (resume_page && addr_in == ulmc_pkg::OFS_RESUME_ONE) begin
        res1_next = wdata_in;
      end else if (resume_page && addr_in == ulmc_pkg::OFS_RESUME_TWO) begin
        res2_next = wdata_in;
      end else if (!s_reg.lc[ulmc_pkg::LC_DIVISOR] && addr_in == ulmc_pkg::OFS_MODEM_CONTROL) begin
        s_next.mc = wdata_in;
      end
    end
    // register reads; overrun clears on status read
    s_next.rdata = 8'h00;
    if (addr_in == ulmc_pkg::OFS_LINE_CONTROL) begin
      s_next.rdata = s_reg.lc;
    end else if (resume_page && addr_in == ulmc_pkg::OFS_RESUME_ONE) begin
      s_next.rdata = res1_reg;
    end else if (resume_page && addr_in == ulmc_pkg::OFS_RESUME_TWO) begin
      s_next.rdata = res2_reg;
    end else if (!s_reg.lc[ulmc_pkg::LC_DIVISOR] && addr_in == ulmc_pkg::OFS_MODEM_CONTROL) begin
      s_next.rdata = s_reg.mc;
    end else if (!s_reg.lc[ulmc_pkg::LC_DIVISOR] && addr_in == ulmc_pkg::OFS_LINE_STATUS) begin
      s_next.rdata = ls;
      if (rd_in) begin
        s_next.overrun = 1'b0;
      end
    end
    // baud tick: prescaler then divisor
    s_next.tick = 1'b0;
    s_next.pre_cnt = s_reg.pre_cnt + 2'd1;
    if (!s_reg.mc[ulmc_pkg::MC_PRESCALE] || s_reg.pre_cnt == ulmc_pkg::PRESCALE_DIV4_LAST) begin
      s_next.pre_cnt = 2'd0;
      if (s_reg.baud_cnt >= 16'(DIVISOR_DEFAULT - 1)) begin
        s_next.baud_cnt = 16'h0000;
        s_next.tick = 1'b1;
      end else begin
        s_next.baud_cnt = s_reg.baud_cnt + 16'd1;
      end
    end
    // holding register
    if (tx_valid_in && !s_reg.thr_full) begin
      s_next.tx_holding_reg = tx_data_in;
      s_next.thr_full = 1'b1;
    end
    // transmitter, sixteen ticks per bit
    if (s_reg.tick) begin
      s_next.tx_sub = s_reg.tx_sub + 4'd1;
      case (s_reg.tx_st)
        TX_IDLE: begin
          s_next.tx_line = 1'b1;
          if (s_reg.thr_full && !s_reg.cts_sync[3]) begin
            // parity sits right after the last data bit
            s_next.tx_shift_reg = {1'b1, s_reg.tx_holding_reg};
            s_next.tx_shift_reg[nbits] = par_bit;
            s_next.thr_full = 1'b0;
            s_next.tx_st = TX_START;
            s_next.tx_sub = 4'h0;
            s_next.tx_line = 1'b0;
          end
        end
        TX_START: begin
          if (s_reg.tx_sub == ulmc_pkg::OVERSAMPLE_LAST) begin
            s_next.tx_st = TX_DATA;
            s_next.tx_bits = 4'h0;
            s_next.tx_line = s_reg.tx_shift_reg[0];
          end
        end
        TX_DATA: begin
          if (s_reg.tx_sub == ulmc_pkg::OVERSAMPLE_LAST) begin
            s_next.tx_bits = s_reg.tx_bits + 4'd1;
            s_next.tx_shift_reg = {1'b1, s_reg.tx_shift_reg[8:1]};
            if (s_reg.tx_bits + 4'd1 == nbits && !s_reg.lc[ulmc_pkg::LC_PAR_EN]) begin
              s_next.tx_line = 1'b1;
            end else if (s_reg.tx_bits + 4'd1 == nbits) begin
              s_next.tx_shift_reg = {1'b1, 8'hFF};
              s_next.tx_line = s_reg.tx_shift_reg[1];
            end else begin
              s_next.tx_line = s_reg.tx_shift_reg[1];
            end
            if (s_reg.tx_bits + 4'd1 == nbits + {3'b000, s_reg.lc[ulmc_pkg::LC_PAR_EN]}) begin
              s_next.tx_st = TX_STOP;
              s_next.tx_ticks = 5'h00;
              s_next.tx_line = 1'b1;
            end
          end
        end
        TX_STOP: begin
          s_next.tx_ticks = s_reg.tx_ticks + 5'd1;
          if ({1'b0, s_reg.tx_ticks} + 6'd1 == stop_len) begin
            s_next.tx_st = TX_IDLE;
          end
        end
        default: s_next.tx_st = TX_IDLE;
      endcase
    end
    // receiver, mid-bit sampling
    if (s_reg.tick) begin
      s_next.rx_sub = s_reg.rx_sub + 4'd1;
      case (s_reg.rx_st)
        RX_IDLE: begin
          if (!rx_in_bit) begin
            s_next.rx_st = RX_START;
            s_next.rx_sub = 4'h0;
          end
        end
        RX_START: begin
          if (s_reg.rx_sub == ulmc_pkg::HALF_BIT) begin
            s_next.rx_st = rx_in_bit ? RX_IDLE : RX_DATA;
            s_next.rx_sub = 4'h0;
            s_next.rx_bits = 4'h0;
            s_next.rx_zero = 1'b1;
            s_next.rsr = 9'h000;
          end
        end
        RX_DATA: begin
          if (s_reg.rx_sub == ulmc_pkg::OVERSAMPLE_LAST) begin
            s_next.rsr[s_reg.rx_bits] = rx_in_bit;
            s_next.rx_zero = s_reg.rx_zero & !rx_in_bit;
            s_next.rx_bits = s_reg.rx_bits + 4'd1;
            if (s_reg.rx_bits + 4'd1 == nbits + {3'b000, s_reg.lc[ulmc_pkg::LC_PAR_EN]}) begin
              s_next.rx_st = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (s_reg.rx_sub == ulmc_pkg::OVERSAMPLE_LAST) begin
            s_next.rx_st = RX_IDLE;
            s_next.rx_data = s_reg.rsr[7:0] & (8'hFF >> (4'd8 - nbits));
            s_next.rx_err[2] = s_reg.rx_zero && !rx_in_bit;
            s_next.rx_err[1] = !rx_in_bit;
            s_next.rx_err[0] = s_reg.lc[ulmc_pkg::LC_PAR_EN]
              && (s_reg.lc[ulmc_pkg::LC_FORCE_PAR]
                  ? (s_reg.rsr[nbits] != ~s_reg.lc[ulmc_pkg::LC_EVEN_PAR])
                  : ((^s_reg.rsr[8:0]) != ~s_reg.lc[ulmc_pkg::LC_EVEN_PAR]));
            s_next.resume = s_reg.mc[ulmc_pkg::MC_RESUME_ANY];
            if (rx_fifo_full_in) begin
              s_next.overrun = 1'b1;
            end else begin
              s_next.rx_push = 1'b1;
            end
          end
        end
        default: s_next.rx_st = RX_IDLE;
      endcase
    end
    // modem pins and status inputs
    s_next.rts_n = auto_rts_in ? auto_rts_level_in : s_reg.mc[ulmc_pkg::MC_RTS] ? 1'b0 : 1'b1;
    s_next.dtr_n = (dtr_sel_in && s_reg.mc[ulmc_pkg::MC_DTR]) ? 1'b0 : 1'b1;
    if (s_reg.mc[ulmc_pkg::MC_LOOPBACK]) begin
      s_next.rts_n = 1'b1;
      s_next.dtr_n = 1'b1;
      s_next.modem_in = {s_reg.mc[ulmc_pkg::MC_SPARE_TWO], s_reg.mc[ulmc_pkg::MC_SPARE_ONE],
                         s_reg.mc[ulmc_pkg::MC_DTR], s_reg.mc[ulmc_pkg::MC_RTS]};
    end else begin
      s_next.modem_in = {~s_reg.pin_sync[5], ~s_reg.pin_sync[4], ~s_reg.pin_sync[3],
                         ~s_reg.cts_sync[3]};
    end
    s_next.upper_page = s_reg.mc[ulmc_pkg::MC_SPARE_ONE]
      && !s_reg.mc[ulmc_pkg::MC_LOOPBACK];
    // loopback parks the pin idle, ahead of break; otherwise break overrides
    if (s_reg.mc[ulmc_pkg::MC_LOOPBACK]) begin
      s_next.tx_pin = 1'b1;
    end else if (s_reg.lc[ulmc_pkg::LC_BREAK]) begin
      s_next.tx_pin = 1'b0;
    end else begin
      s_next.tx_pin = s_next.tx_line;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_reg <= '0;
      s_reg.lc <= ulmc_pkg::LINE_CONTROL_RST;
      s_reg.mc <= ulmc_pkg::MODEM_CONTROL_RST;
      s_reg.tx_st <= TX_IDLE;
      s_reg.rx_st <= RX_IDLE;
      s_reg.tx_line <= 1'b1;
      s_reg.rx_sync <= 2'b11;
      s_reg.cts_sync <= 4'hF;
      s_reg.rts_n <= 1'b1;
      s_reg.dtr_n <= 1'b1;
      s_reg.rdata <= 8'h00;
      s_reg.pin_sync <= 6'h3F;
      s_reg.tx_pin <= 1'b1;
      s_reg.upper_page <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // resume characters survive soft resets
  always_ff @(posedge clk_in or negedge por_n_in) begin
    if (!por_n_in) begin
      res1_reg <= ulmc_pkg::RESUME_RST;
      res2_reg <= ulmc_pkg::RESUME_RST;
    end else begin
      res1_reg <= res1_next;
      res2_reg <= res2_next;
    end
  end

  assign rdata_out = s_reg.rdata;
  assign divisor_sel_out = s_reg.lc[ulmc_pkg::LC_DIVISOR];
  assign upper_page_out = s_reg.upper_page;
  assign tx_ready_out = !s_reg.thr_full;
  assign rx_push_out = s_reg.rx_push;
  assign rx_data_out = s_reg.rx_data;
  assign rx_err_out = s_reg.rx_err;
  assign resume_tx_out = s_reg.resume;
  assign tx_pin_out = s_reg.tx_pin;
  assign rts_n_out = s_reg.rts_n;
  assign dtr_n_out = s_reg.dtr_n;
  assign modem_in_out = s_reg.modem_in;
endmodule // ulmc_core
`default_nettype wire

/* pkg/ulmc_pkg.sv */
// constants for the uart line, modem and status control block
package ulmc_pkg;
  // register offsets
  localparam logic [2:0] OFS_LINE_CONTROL = 3'h3;
  localparam logic [2:0] OFS_MODEM_CONTROL = 3'h4;
  localparam logic [2:0] OFS_LINE_STATUS = 3'h5;
  localparam logic [2:0] OFS_RESUME_ONE = 3'h4;
  localparam logic [2:0] OFS_RESUME_TWO = 3'h5;
  localparam logic [7:0] RESUME_PAGE_KEY = 8'hBF;
  // reset values
  localparam logic [7:0] LINE_CONTROL_RST = 8'h00;
  localparam logic [7:0] MODEM_CONTROL_RST = 8'h00;
  localparam logic [7:0] LINE_STATUS_RST = 8'h60;
  localparam logic [7:0] RESUME_RST = 8'h00;
  // line control fields
  localparam int LC_DIVISOR = 7;
  localparam int LC_BREAK = 6;
  localparam int LC_FORCE_PAR = 5;
  localparam int LC_EVEN_PAR = 4;
  localparam int LC_PAR_EN = 3;
  localparam int LC_STOP = 2;
  // modem control fields
  localparam int MC_PRESCALE = 7;
  localparam int MC_INFRARED = 6;
  localparam int MC_RESUME_ANY = 5;
  localparam int MC_LOOPBACK = 4;
  localparam int MC_SPARE_TWO = 3;
  localparam int MC_SPARE_ONE = 2;
  localparam int MC_RTS = 1;
  localparam int MC_DTR = 0;
  // line status fields
  localparam int LS_FIFO_ERR = 7;
  localparam int LS_TX_IDLE = 6;
  localparam int LS_THR_EMPTY = 5;
  localparam int LS_BREAK = 4;
  localparam int LS_FRAMING = 3;
  localparam int LS_PARITY = 2;
  localparam int LS_OVERRUN = 1;
  localparam int LS_READY = 0;
  // timing
  localparam logic [1:0] PRESCALE_DIV4_LAST = 2'h3;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] HALF_BIT = 4'h7;
  localparam logic [4:0] HALF_STOP_TICKS = 5'h08;
  localparam logic [4:0] FULL_STOP_TICKS = 5'h10;
endpackage

/* test/ulmc_checker.sv */
// port assertions for the uart line and modem control core
`timescale 1ns/1ns
`default_nettype none
module ulmc_checker (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic por_n_in,
  input wire logic [2:0] addr_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  input wire logic feature_bit2_in,
  input wire logic auto_rts_in,
  input wire logic auto_rts_level_in,
  input wire logic dtr_sel_in,
  input wire logic rx_fifo_err_any_in,
  input wire logic [2:0] rx_head_err_in,
  input wire logic [7:0] rdata_out,
  input wire logic divisor_sel_out,
  input wire logic upper_page_out,
  input wire logic tx_ready_out,
  input wire logic tx_pin_out,
  input wire logic rts_n_out,
  input wire logic dtr_n_out,
  input wire logic [3:0] modem_in_out
);
  logic [7:0] lc, mc, x1, x2, xr;
  logic [3:0] lb;
  logic key, ls, ers, edt;
  assign key = lc == 8'hBF && !feature_bit2_in;
  assign ls = addr_in == 3'h5 && !lc[7];
  assign xr = addr_in[0] ? x2 : x1;
  assign ers = mc[4] | (auto_rts_in ? auto_rts_level_in : !mc[1]);
  assign edt = mc[4] | !mc[0];
  assign lb = {mc[3], mc[2], mc[0], mc[1]};
  // shadows rebuilt from write strobes
  always_ff @(posedge clk_in or negedge resetn_in)
    if (!resetn_in) {lc, mc} <= 16'h0000;
    else if (wr_in && addr_in == 3'h3) lc <= wdata_in;
    else if (wr_in && addr_in == 3'h4 && !lc[7]) mc <= wdata_in;
  // resume shadows survive the ordinary reset
  always_ff @(posedge clk_in or negedge por_n_in)
    if (!por_n_in) {x1, x2} <= 16'h0000;
    else if (wr_in && key && addr_in == 3'h4) x1 <= wdata_in;
    else if (wr_in && key && addr_in == 3'h5) x2 <= wdata_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  AST_DIVISOR: assert property (wr_in && addr_in == 3'h3 |=> divisor_sel_out == lc[7])
    else $error("divisor select wrong");
  AST_BREAK: assert property (lc[6] && !mc[4] && $stable({lc, mc}) |-> !tx_pin_out)
    else $error("break not holding tx low");
  AST_RTS: assert property ($stable(ers) |-> rts_n_out == ers)
    else $error("rts level wrong");
  AST_DTR: assert property (dtr_sel_in && $past(dtr_sel_in) && $stable(edt) |-> dtr_n_out == edt)
    else $error("dtr level wrong");
  AST_LOOP: assert property ($stable(mc)[*3] ##0 mc[4] |-> modem_in_out == lb)
    else $error("loopback status wrong");
  AST_PAGE: assert property ($stable(mc) |-> upper_page_out == (mc[2] && !mc[4]))
    else $error("page select wrong");
  AST_STATUS: assert property (ls |=> rdata_out[7] == $past(rx_fifo_err_any_in))
    else $error("status error flag wrong");
  AST_RX_ERR: assert property (ls |=> rdata_out[4:2] == $past(rx_head_err_in))
    else $error("status head error bits wrong");
  AST_THR: assert property (ls |=> rdata_out[5] == $past(tx_ready_out))
    else $error("holding empty flag wrong");
  AST_RESUME: assert property (disable iff (!resetn_in || !por_n_in)
    key && !wr_in && addr_in[2:1] == 2'h2 |=> rdata_out == $past(xr))
    else $error("resume character read wrong");
  COV_LOOP: cover property (mc[4] && mc[3]);
  COV_BREAK: cover property (lc[6] && !tx_pin_out);
  COV_KEY: cover property (key && addr_in == 3'h4);
endmodule // ulmc_checker
bind ulmc_core ulmc_checker u_chk (.*);
`default_nettype wire

/* test/ulmc_remote.sv */
// far serial device: drives the receive line and modem pins
`timescale 1ns/1ns
`default_nettype none
module ulmc_remote #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk_in,
  output logic rx_out,
  output logic cts_n_out,
  output logic dsr_n_out,
  output logic dcd_n_out,
  output logic ri_n_out
);
  // idle line at mark; only clear-to-send asserted
  initial begin
    rx_out = 1'b1;
    {dcd_n_out, ri_n_out, dsr_n_out, cts_n_out} = 4'hE;
  end
  task automatic modem(input logic [3:0] n);
    {dcd_n_out, ri_n_out, dsr_n_out, cts_n_out} = n;
  endtask
  // raw frame lsb first, so malformed frames can be sent on purpose
  task automatic send(input logic [10:0] bits);
    for (int i = 0; i < 11; i++) begin
      rx_out = bits[i];
      repeat (BIT_CLKS) @(negedge clk_in);
    end
    rx_out = 1'b1;
  endtask
endmodule // ulmc_remote
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the uart line, modem and status core
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_in = 1'b0, resetn_in = 1'b0, por_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic feature_bit2_in = 1'b0, auto_rts_in = 1'b0, auto_rts_level_in = 1'b0;
  logic dtr_sel_in = 1'b1, tx_valid_in = 1'b0, rx_fifo_full_in = 1'b0;
  logic rx_fifo_ready_in = 1'b0, rx_fifo_err_any_in = 1'b0;
  logic [2:0] addr_in = 3'h0, rx_head_err_in = 3'h0;
  logic [7:0] wdata_in = 8'h00, tx_data_in = 8'h00;
  logic rx_pin_in, cts_n_in, dsr_n_in, dcd_n_in, ri_n_in;
  logic divisor_sel_out, upper_page_out, tx_ready_out, rx_push_out, resume_tx_out;
  logic tx_pin_out, rts_n_out, dtr_n_out;
  logic [7:0] rdata_out, rx_data_out;
  logic [2:0] rx_err_out;
  logic [3:0] modem_in_out;
  int failures = 0, n_checks = 0, cyc = 0, n_resume = 0;
  ulmc_core dut (.*);
  ulmc_remote u_far (.clk_in(clk_in), .rx_out(rx_pin_in), .cts_n_out(cts_n_in),
    .dsr_n_out(dsr_n_in), .dcd_n_out(dcd_n_in), .ri_n_out(ri_n_in));
  always #20 clk_in = ~clk_in;
  always @(negedge clk_in) begin
    cyc++;
    if (resume_tx_out === 1'b1) n_resume++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_in = a;
    wdata_in = d;
    wr_in = 1'b1;
    @(negedge clk_in);
    wr_in = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [11:0] exp);
    @(negedge clk_in);
    addr_in = a;
    rd_in = 1'b1;
    @(negedge clk_in);
    rd_in = 1'b0;
    chk(rdata_out, exp);
  endtask
  task automatic rx_frame(input logic [10:0] fr, input logic [11:0] exp);
    fork
      u_far.send(fr);
      begin
        for (int i = 0; i < 400 && rx_push_out !== 1'b1; i++) @(negedge clk_in);
        chk({1'b0, rx_err_out, rx_data_out}, exp);
      end
    join
  endtask
  task automatic t_basic();
    rdc(3'h5, 12'h060);
    rdc(3'h4, 12'h000);
    chk({rts_n_out, dtr_n_out, tx_pin_out, tx_ready_out}, 12'h00F);
    wr(3'h3, 8'h80);
    chk(divisor_sel_out, 12'h001);
    wr(3'h4, 8'h02);
    chk(rts_n_out, 12'h001);
    wr(3'h3, 8'h43);
    chk({divisor_sel_out, tx_pin_out}, 12'h000);
    wr(3'h3, 8'h03);
    chk(tx_pin_out, 12'h001);
    $display("test basic done");
  endtask
  task automatic t_modem();
    wr(3'h4, 8'h03);
    chk({rts_n_out, dtr_n_out}, 12'h000);
    auto_rts_in = 1'b1;
    auto_rts_level_in = 1'b1;
    repeat (2) @(negedge clk_in);
    chk(rts_n_out, 12'h001);
    auto_rts_in = 1'b0;
    wr(3'h4, 8'h04);
    chk(upper_page_out, 12'h001);
    wr(3'h4, 8'h1D);
    repeat (3) @(negedge clk_in);
    chk(modem_in_out, 12'h00E);
    chk({upper_page_out, tx_pin_out, rts_n_out, dtr_n_out}, 12'h007);
    u_far.modem(4'hA);
    wr(3'h4, 8'h00);
    repeat (3) @(negedge clk_in);
    chk(modem_in_out, 12'h005);
    $display("test modem done");
  endtask
  task automatic t_resume();
    wr(3'h3, 8'hBF);
    wr(3'h4, 8'h11);
    wr(3'h5, 8'h22);
    rdc(3'h4, 12'h011);
    rdc(3'h5, 12'h022);
    feature_bit2_in = 1'b1;
    rdc(3'h4, 12'h000);
    feature_bit2_in = 1'b0;
    resetn_in = 1'b0;
    @(negedge clk_in);
    resetn_in = 1'b1;
    wr(3'h3, 8'hBF);
    rdc(3'h4, 12'h011);
    por_n_in = 1'b0;
    @(negedge clk_in);
    por_n_in = 1'b1;
    rdc(3'h5, 12'h000);
    wr(3'h3, 8'h03);
    $display("test resume done");
  endtask
  task automatic t_status();
    rx_fifo_ready_in = 1'b1;
    rx_fifo_err_any_in = 1'b1;
    rx_head_err_in = 3'h7;
    rdc(3'h5, 12'h0FD);
    rx_head_err_in = 3'h2;
    rdc(3'h5, 12'h0E9);
    {rx_fifo_ready_in, rx_fifo_err_any_in, rx_head_err_in} = 5'h00;
    $display("test status done");
  endtask
  task automatic t_tx();
    logic [7:0] lcv [4] = '{8'h0B, 8'h1B, 8'h2B, 8'h3B};
    logic [10:0] f;
    int g, w;
    for (int k = 0; k < 4; k++) begin
      wr(3'h3, lcv[k]);
      tx_data_in = 8'h5A;
      tx_valid_in = 1'b1;
      @(negedge clk_in);
      tx_valid_in = 1'b0;
      for (int i = 0; i < 400 && tx_pin_out; i++) @(negedge clk_in);
      repeat (8) @(negedge clk_in);
      for (int i = 0; i < 11; i++) begin
        f[i] = tx_pin_out;
        repeat (16) @(negedge clk_in);
      end
      chk(f[8:0], 12'h0B4);
      chk(f[10:9], {1'b1, ~k[0]});
    end
    // two stop bits: next start no earlier than twelve bit times later
    wr(3'h3, 8'h0F);
    tx_data_in = 8'hFF;
    tx_valid_in = 1'b1;
    @(negedge clk_in);
    tx_valid_in = 1'b0;
    for (int i = 0; i < 400 && tx_pin_out; i++) @(negedge clk_in);
    tx_valid_in = 1'b1;
    @(negedge clk_in);
    tx_valid_in = 1'b0;
    g = 1;
    while (!tx_pin_out && g < 400) begin
      @(negedge clk_in);
      g++;
    end
    while (tx_pin_out && g < 400) begin
      @(negedge clk_in);
      g++;
    end
    chk(g >= 192, 12'h001);
    repeat (250) @(negedge clk_in);
    // prescaler: start bit lasts four times sixteen clocks
    wr(3'h4, 8'h80);
    tx_valid_in = 1'b1;
    @(negedge clk_in);
    tx_valid_in = 1'b0;
    for (int i = 0; i < 400 && tx_pin_out; i++) @(negedge clk_in);
    w = 0;
    while (!tx_pin_out && w < 400) begin
      @(negedge clk_in);
      w++;
    end
    chk(w, 12'd64);
    repeat (800) @(negedge clk_in);
    wr(3'h4, 8'h00);
    rdc(3'h5, 12'h060);
    $display("test transmit done");
  endtask
  task automatic t_rx();
    wr(3'h3, 8'h1B);
    wr(3'h4, 8'h20);
    rx_frame({2'b10, 8'hA5, 1'b0}, 12'h0A5);
    rx_frame({2'b11, 8'hA5, 1'b0}, 12'h1A5);
    rx_frame({2'b00, 8'hA5, 1'b0}, 12'h2A5);
    chk(n_resume, 12'h003);
    rx_fifo_full_in = 1'b1;
    u_far.send({2'b10, 8'hA5, 1'b0});
    rx_fifo_full_in = 1'b0;
    rdc(3'h5, 12'h062);
    rdc(3'h5, 12'h060);
    rx_frame(11'h000, 12'h600);
    $display("test receive done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk_in);
    resetn_in = 1'b1;
    por_n_in = 1'b1;
    t_basic();
    t_modem();
    t_resume();
    t_status();
    t_tx();
    t_rx();
    stop_test();
  end
endmodule // tb
`default_nettype wire
